// ==== logic/fcs_pkg.sv ====
/*
 * Constants and carrier types for the flash command sequencer.
 * Assumes a 16-bit CPU write/read strobe interface and a word-wide flash array port.
 */
package fcs_pkg;
    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLR_STATUS  = 8'h50;
    localparam logic [7:0] CMD_PROGRAM     = 8'h40;
    localparam logic [7:0] CMD_BLK_ERASE   = 8'h20;
    localparam logic [7:0] CMD_ERASE_ALL   = 8'hA7;
    localparam logic [7:0] CMD_LOCK_PROG   = 8'h77;
    localparam logic [7:0] CMD_LOCK_READ   = 8'h71;
    localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
    // ------------------------------------------------------------------
    // Geometry and status layout
    // ------------------------------------------------------------------
    localparam int          ADDR_W         = 20;
    localparam int          NUM_BLOCKS     = 14;
    localparam int          BLK_W          = 4;
    localparam logic [3:0]  ERASE_ALL_LAST = 4'hC;
    localparam logic [3:0]  BOOT_BLOCK     = 4'hD;
    localparam int          SR_READY_POS   = 7;
    localparam int          SR_ERASE_POS   = 5;
    localparam int          SR_PROG_POS    = 4;
    localparam logic [15:0] ERASED_WORD    = 16'hFFFF;
    // ------------------------------------------------------------------
    // Operation timing in cycles at 20 MHz
    // ------------------------------------------------------------------
    localparam logic [11:0] PROG_CYCLES    = 12'h040;
    localparam logic [11:0] ERASE_CYCLES   = 12'h100;
    localparam logic [11:0] LOCK_CYCLES    = 12'h020;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [15:0]       wdata;
    } fcs_bus_t;

    typedef struct packed {
        logic              wr;
        logic              erase;
        logic [ADDR_W-1:0] addr;
        logic [BLK_W-1:0]  blk;
        logic [15:0]       wdata;
    } fcs_array_t;
endpackage : fcs_pkg

// ==== logic/fcs_sequencer.sv ====
/*
 * Flash command sequencer: decodes two-cycle CPU commands, runs auto program,
 * auto erase and lock operations, keeps status flags and per-block lock bits.
 * Assumes the flash array answers reads combinationally with arr_rdata,
 * reports verify failure on arr_fail, and that the block map is given by blk_of.
 */
`timescale 1ns/1ps
module fcs_sequencer #(
    parameter logic [11:0] PROG_T  = fcs_pkg::PROG_CYCLES,
    parameter logic [11:0] ERASE_T = fcs_pkg::ERASE_CYCLES,
    parameter logic [11:0] LOCK_T  = fcs_pkg::LOCK_CYCLES
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire fcs_pkg::fcs_bus_t        bus,
    input  wire logic                     ram_resident_rewrite_mode,
    input  wire logic                     lock_protect_disable,
    input  wire logic [fcs_pkg::BLK_W-1:0] blk_of,
    input  wire logic                     blk_top,
    input  wire logic [15:0]              arr_rdata,
    input  wire logic                     arr_fail,
    output logic [15:0]                   rdata,
    output logic                          sequencer_ready_flag,
    output logic                          program_error_flag,
    output logic                          erase_error_flag,
    output logic                          lock_state_result,
    output fcs_pkg::fcs_array_t           arr
);
    import fcs_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE, S_WAIT2, S_PROG, S_ERASE, S_LOCK, S_READLK
    } fcs_state_t;
    typedef enum logic [1:0] {
        M_ARRAY, M_STATUS, M_ONESHOT
    } fcs_rmode_t;

    fcs_state_t              state, next_state;
    fcs_rmode_t              rmode, next_rmode;
    logic [7:0]              cmd, next_cmd;
    logic [BLK_W-1:0]        blk, next_blk;
    logic [11:0]             cnt, next_cnt;
    logic [NUM_BLOCKS-1:0]   lock_bits, next_lock_bits;
    logic                    ready, next_ready;
    logic                    perr, next_perr;
    logic                    eerr, next_eerr;
    logic                    fail_acc, next_fail_acc;
    logic                    lkres, next_lkres;
    logic [15:0]             next_rdata;
    fcs_array_t              next_arr;
    logic [7:0]              status;
    logic [7:0]              lo;
    logic                    unlocked;
    logic                    err_any;

    assign lo       = bus.wdata[7:0];
    assign unlocked = lock_protect_disable | lock_bits[blk_of];
    assign err_any  = perr | eerr;

    always_comb begin
        status               = 8'h00;
        status[SR_READY_POS] = ready;
        status[SR_ERASE_POS] = eerr;
        status[SR_PROG_POS]  = perr;
    end

    // ------------------------------------------------------------------
    // Command decode and operation sequencing
    // ------------------------------------------------------------------
    always_comb begin
        next_state     = state;
        next_rmode     = rmode;
        next_cmd       = cmd;
        next_blk       = blk;
        next_cnt       = cnt;
        next_lock_bits = lock_bits;
        next_ready     = ready;
        next_perr      = perr;
        next_eerr      = eerr;
        next_fail_acc  = fail_acc;
        next_lkres     = lkres;
        next_arr       = '0;
        case (state)
            S_IDLE: begin
                if (bus.rd && rmode == M_ONESHOT) begin
                    next_rmode = M_ARRAY;
                end
                if (bus.wr) begin
                    next_cmd   = lo;
                    case (lo)
                        CMD_READ_ARRAY:  next_rmode = M_ARRAY;
                        CMD_READ_STATUS: next_rmode = M_ONESHOT;
                        CMD_CLR_STATUS: begin
                            next_perr = 1'b0;
                            next_eerr = 1'b0;
                        end
                        CMD_PROGRAM, CMD_BLK_ERASE, CMD_ERASE_ALL, CMD_LOCK_PROG: begin
                            if (!err_any) begin
                                next_state = S_WAIT2;
                            end
                        end
                        CMD_LOCK_READ:   next_state = S_WAIT2;
                        default:         next_state = S_IDLE;
                    endcase
                end
            end
            S_WAIT2: begin
                if (bus.wr) begin
                    next_state = S_IDLE;
                    if (cmd == CMD_PROGRAM) begin
                        if (!unlocked) begin
                            next_perr = 1'b1;
                        end else if (arr_rdata != ERASED_WORD) begin
                            next_perr = 1'b1;
                        end else begin
                            next_arr.wr    = 1'b1;
                            next_arr.addr  = bus.addr;
                            next_arr.wdata = bus.wdata;
                            next_cnt       = PROG_T;
                            next_ready     = 1'b0;
                            next_state     = S_PROG;
                        end
                        if (ram_resident_rewrite_mode) begin
                            next_rmode = M_STATUS;
                        end
                    end else if (lo == CMD_READ_ARRAY) begin
                        next_rmode = M_ARRAY;
                    end else if (lo != CMD_CONFIRM) begin
                        if (cmd != CMD_LOCK_READ) begin
                            next_perr = 1'b1;
                            next_eerr = 1'b1;
                        end
                    end else begin
                        next_ready    = 1'b0;
                        next_fail_acc = 1'b0;
                        case (cmd)
                            CMD_BLK_ERASE: begin
                                if (!unlocked) begin
                                    next_eerr  = 1'b1;
                                    next_ready = 1'b1;
                                end else begin
                                    next_blk   = blk_of;
                                    next_cnt   = ERASE_T;
                                    next_state = S_ERASE;
                                end
                                if (ram_resident_rewrite_mode) begin
                                    next_rmode = M_STATUS;
                                end
                            end
                            CMD_ERASE_ALL: begin
                                next_blk   = '0;
                                next_cnt   = ERASE_T;
                                next_state = S_ERASE;
                                if (ram_resident_rewrite_mode) begin
                                    next_rmode = M_STATUS;
                                end
                            end
                            CMD_LOCK_PROG: begin
                                next_blk   = blk_of;
                                next_cnt   = LOCK_T;
                                next_state = S_LOCK;
                            end
                            default: begin
                                next_blk   = blk_of;
                                next_cnt   = LOCK_T;
                                next_state = S_READLK;
                                next_rmode = M_ARRAY;
                            end
                        endcase
                    end
                end
            end
            S_PROG: begin
                next_cnt = cnt - 12'h001;
                if (cnt == 12'h001) begin
                    next_perr  = arr_fail;
                    next_ready = 1'b1;
                    next_state = S_IDLE;
                end
            end
            S_ERASE: begin
                next_cnt = cnt - 12'h001;
                if (cnt == ERASE_T) begin
                    if (cmd == CMD_ERASE_ALL && !unlocked_blk(blk)) begin
                        next_cnt = 12'h001;
                    end else begin
                        next_arr.erase = 1'b1;
                        next_arr.blk   = blk;
                    end
                end
                if (cnt == 12'h001) begin
                    if (cmd != CMD_ERASE_ALL || unlocked_blk(blk)) begin
                        next_fail_acc       = fail_acc | arr_fail;
                        next_lock_bits[blk] = 1'b1;
                    end
                    if (cmd == CMD_ERASE_ALL && blk != ERASE_ALL_LAST) begin
                        next_blk = blk + 4'h1;
                        next_cnt = ERASE_T;
                    end else begin
                        next_eerr  = next_fail_acc;
                        next_ready = 1'b1;
                        next_state = S_IDLE;
                    end
                end
            end
            S_LOCK: begin
                next_cnt = cnt - 12'h001;
                if (cnt == 12'h001) begin
                    next_lock_bits[blk] = 1'b0;
                    next_perr  = arr_fail;
                    next_ready = 1'b1;
                    next_state = S_IDLE;
                end
            end
            S_READLK: begin
                next_cnt = cnt - 12'h001;
                if (cnt == 12'h001) begin
                    next_lkres = lock_bits[blk];
                    next_ready = 1'b1;
                    next_state = S_IDLE;
                end
            end
            default: next_state = S_IDLE;
        endcase
    end

    function automatic logic unlocked_blk(input logic [BLK_W-1:0] b);
        unlocked_blk = lock_protect_disable | lock_bits[b];
    endfunction : unlocked_blk

    always_comb begin
        if (rmode == M_ARRAY) begin
            next_rdata = arr_rdata;
        end else begin
            next_rdata = {8'h00, status};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= S_IDLE;
            rmode     <= M_ARRAY;
            cmd       <= CMD_READ_ARRAY;
            blk       <= '0;
            cnt       <= '0;
            lock_bits <= '1;
            ready     <= 1'b1;
            perr      <= 1'b0;
            eerr      <= 1'b0;
            fail_acc  <= 1'b0;
            lkres     <= 1'b0;
            rdata     <= '0;
            arr       <= '0;
        end else begin
            state     <= next_state;
            rmode     <= next_rmode;
            cmd       <= next_cmd;
            blk       <= next_blk;
            cnt       <= next_cnt;
            lock_bits <= next_lock_bits;
            ready     <= next_ready;
            perr      <= next_perr;
            eerr      <= next_eerr;
            fail_acc  <= next_fail_acc;
            lkres     <= next_lkres;
            rdata     <= next_rdata;
            arr       <= next_arr;
        end
    end

    assign sequencer_ready_flag = ready;
    assign program_error_flag   = perr;
    assign erase_error_flag     = eerr;
    assign lock_state_result    = lkres;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_prog_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
        state == S_PROG |-> !ready)
        else $error("ready high during program");
    a_prog_done: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == S_PROG && cnt == 12'h001) |=> ready && state == S_IDLE)
        else $error("program did not finish");
    a_clear_errs: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == S_IDLE && bus.wr && lo == CMD_CLR_STATUS) |=> !perr && !eerr)
        else $error("clear status failed");
    a_err_refuse: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == S_IDLE && bus.wr && err_any && lo == CMD_PROGRAM) |=> state == S_IDLE)
        else $error("command accepted with error set");
    a_seq_error: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == S_WAIT2 && bus.wr && cmd == CMD_BLK_ERASE && lo != CMD_CONFIRM
         && lo != CMD_READ_ARRAY) |=> perr && eerr)
        else $error("sequence error not flagged");
    a_erase_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
        state == S_ERASE |-> !ready)
        else $error("ready high during erase");
    a_lock_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == S_LOCK && cnt == 12'h001) |=> !lock_bits[$past(blk)])
        else $error("lock bit not cleared");
    a_status_view: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rmode == M_STATUS) |=> rdata[SR_READY_POS] == $past(ready))
        else $error("status not shown");
    a_boot_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == S_ERASE && cmd == CMD_ERASE_ALL) |-> blk != BOOT_BLOCK)
        else $error("erase-all reached boot block");
endmodule : fcs_sequencer

// ==== test/fcs_flash_model.sv ====
/*
 * Flash array model: word store, block map and block erase.
 * Assumes one-cycle program and erase pulses from the sequencer.
 */
`timescale 1ns/1ps
module fcs_flash_model (
    input  wire logic                      core_clk,
    input  wire fcs_pkg::fcs_bus_t         bus,
    input  wire fcs_pkg::fcs_array_t       arr,
    output logic [fcs_pkg::BLK_W-1:0]      blk_of,
    output logic                           blk_top,
    output logic [15:0]                    arr_rdata
);
    import fcs_pkg::*;
    logic [15:0] mem [0:15][0:2047];
    // ------------------------------------------------------------------
    // Block map and read path.
    // ------------------------------------------------------------------
    assign blk_of    = (bus.addr[15:12] > BOOT_BLOCK) ? BOOT_BLOCK : bus.addr[15:12];
    assign blk_top   = (bus.addr[11:0] == 12'hFFE);
    assign arr_rdata = mem[bus.addr[15:12]][bus.addr[11:1]];
    // ------------------------------------------------------------------
    // Program clears bits only; erase returns a block to all ones.
    // ------------------------------------------------------------------
    initial begin
        for (int b = 0; b < 16; b++) for (int w = 0; w < 2048; w++) mem[b][w] = ERASED_WORD;
    end
    always @(posedge core_clk) begin
        if (arr.wr) mem[arr.addr[15:12]][arr.addr[11:1]] &= arr.wdata;
        if (arr.erase) for (int w = 0; w < 2048; w++) mem[arr.blk][w] = ERASED_WORD;
    end
endmodule : fcs_flash_model

// ==== test/tb_fcs_sequencer.sv ====
/*
 * Self-checking testbench for the flash command sequencer.
 * Assumes the array model answers reads combinationally; short op counts.
 */
`timescale 1ns/1ps
module tb_fcs_sequencer;
    import fcs_pkg::*;
    localparam logic [11:0] T = 12'h004;
    logic             core_clk = 1'b0;
    logic             rst_n = 1'b0;
    fcs_bus_t         bus = '0;
    logic             ram_mode = 1'b0;
    logic             lpd = 1'b0;
    logic             arr_fail = 1'b0;
    logic [BLK_W-1:0] blk_of;
    logic             blk_top;
    logic [15:0]      arr_rdata;
    logic [15:0]      rdata;
    logic [15:0]      rv;
    logic             rdy;
    logic             perr;
    logic             eerr;
    logic             lsr;
    fcs_array_t       arr;
    int               fail_count = 0;
    int               cmp_count = 0;
    always #25 core_clk = ~core_clk;
    fcs_sequencer #(.PROG_T(T), .ERASE_T(T), .LOCK_T(T)) u_fcs_sequencer (
        .core_clk(core_clk), .rst_n(rst_n), .bus(bus), .ram_resident_rewrite_mode(ram_mode),
        .lock_protect_disable(lpd), .blk_of(blk_of), .blk_top(blk_top),
        .arr_rdata(arr_rdata), .arr_fail(arr_fail), .rdata(rdata),
        .sequencer_ready_flag(rdy), .program_error_flag(perr),
        .erase_error_flag(eerr), .lock_state_result(lsr), .arr(arr));
    fcs_flash_model u_fcs_flash_model (.core_clk(core_clk), .bus(bus), .arr(arr),
        .blk_of(blk_of), .blk_top(blk_top), .arr_rdata(arr_rdata));
    // ------------------------------------------------------------------
    // Shared bus and comparison tasks.
    // ------------------------------------------------------------------
    function automatic logic [19:0] ad(input int b, input int o);
        return {4'h0, b[3:0], o[11:0]};
    endfunction : ad
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic wr(input logic [19:0] a, input logic [15:0] d);
        @(posedge core_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [19:0] a);
        @(posedge core_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1 rv = rdata;
    endtask : rd
    task automatic wait_rdy;
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk(rdy, 1'b1, "ready not back");
    endtask : wait_rdy
    // Mode 0: refused, 1: runs an operation, 2: either.
    task automatic run(input logic [19:0] a, input logic [7:0] c, input logic [15:0] d,
                       input int mode);
        wr(a, {8'hA5, c});
        wr(a, d);
        @(posedge core_clk);
        #1 if (mode == 1) chk(rdy, 1'b0, "not busy");
        if (mode == 0) chk(rdy, 1'b1, "refused op ran");
        wait_rdy();
    endtask : run
    task automatic clr;
        wr(ad(0, 0), {8'h3C, CMD_CLR_STATUS});
        @(posedge core_clk);
        #1 chk({perr, eerr}, 2'b00, "flags not cleared");
    endtask : clr
    task automatic rd_chk(input logic [19:0] a, input logic [15:0] exp);
        rd(a);
        chk(rv, exp, "array word");
    endtask : rd_chk
    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_program;
        chk({rdy, perr, eerr, lsr}, 4'b1000, "reset flags");
        run(ad(1, 12'h010), CMD_PROGRAM, 16'h1234, 1);
        chk(perr, 1'b0, "program error");
        wr(ad(1, 0), {8'h00, CMD_READ_ARRAY});
        rd_chk(ad(1, 12'h010), 16'h1234);
        rd_chk(ad(1, 12'h012), ERASED_WORD);
    endtask : t_program
    task automatic t_reprog;
        run(ad(1, 12'h010), CMD_PROGRAM, 16'h0000, 2);
        chk(perr, 1'b1, "reprogram accepted");
        @(posedge core_clk);
        ram_mode <= 1'b1;
        wr(ad(1, 0), {8'hFF, CMD_READ_STATUS});
        rd(ad(1, 12'h010));
        chk(rv[7:0] & 8'hB0, 8'h90, "status image");
        run(ad(3, 12'hFFE), CMD_BLK_ERASE, {8'h5A, CMD_CONFIRM}, 0);
        clr();
        wr(ad(1, 0), {8'h00, CMD_READ_ARRAY});
        rd_chk(ad(1, 12'h010), 16'h1234);
    endtask : t_reprog
    task automatic t_lock;
        run(ad(2, 12'hFFE), CMD_LOCK_PROG, {8'h11, CMD_CONFIRM}, 1);
        run(ad(2, 12'hFFE), CMD_LOCK_READ, {8'h22, CMD_CONFIRM}, 1);
        chk(lsr, 1'b0, "lock state");
        run(ad(2, 12'h010), CMD_PROGRAM, 16'h1111, 0);
        chk({eerr, perr}, 2'b01, "locked program");
        clr();
        run(ad(2, 12'hFFE), CMD_BLK_ERASE, {8'h00, CMD_CONFIRM}, 0);
        chk({eerr, perr}, 2'b10, "locked erase");
        clr();
        @(posedge core_clk);
        lpd <= 1'b1;
        run(ad(2, 12'hFFE), CMD_BLK_ERASE, {8'h00, CMD_CONFIRM}, 1);
        chk(eerr, 1'b0, "override erase");
        @(posedge core_clk);
        lpd <= 1'b0;
        run(ad(2, 12'hFFE), CMD_LOCK_READ, {8'h00, CMD_CONFIRM}, 1);
        chk(lsr, 1'b1, "erase unlocks");
    endtask : t_lock
    task automatic t_badseq;
        run(ad(4, 12'hFFE), CMD_BLK_ERASE, 16'h0055, 0);
        chk({eerr, perr}, 2'b11, "sequence error");
        clr();
        run(ad(4, 12'hFFE), CMD_LOCK_PROG, {8'h00, CMD_READ_ARRAY}, 0);
        chk({eerr, perr}, 2'b00, "cancel flags");
        rd_chk(ad(1, 12'h010), 16'h1234);
    endtask : t_badseq
    task automatic t_erase_all;
        run(ad(13, 12'h010), CMD_PROGRAM, 16'h3333, 1);
        run(ad(0, 12'h010), CMD_PROGRAM, 16'h4444, 1);
        run(ad(5, 12'h010), CMD_PROGRAM, 16'h5555, 1);
        run(ad(5, 12'hFFE), CMD_LOCK_PROG, {8'h00, CMD_CONFIRM}, 1);
        run(ad(0, 0), CMD_ERASE_ALL, {8'hEE, CMD_CONFIRM}, 1);
        chk(eerr, 1'b0, "erase all error");
        wr(ad(0, 0), {8'h00, CMD_READ_ARRAY});
        rd_chk(ad(0, 12'h010), ERASED_WORD);
        rd_chk(ad(13, 12'h010), 16'h3333);
        rd_chk(ad(5, 12'h010), 16'h5555);
        run(ad(13, 12'hFFE), CMD_BLK_ERASE, {8'h00, CMD_CONFIRM}, 1);
        wr(ad(0, 0), {8'h00, CMD_READ_ARRAY});
        rd_chk(ad(13, 12'h010), ERASED_WORD);
    endtask : t_erase_all
    task automatic t_ram_mode;
        @(posedge core_clk);
        ram_mode <= 1'b1;
        wr(ad(6, 12'h010), {8'h00, CMD_PROGRAM});
        wr(ad(6, 12'h010), 16'h6666);
        rd(ad(6, 12'h010));
        chk(rv[7], 1'b0, "status busy");
        wait_rdy();
        rd(ad(6, 12'h010));
        chk(rv[7], 1'b1, "status ready");
        rd(ad(6, 12'h010));
        chk(rv[7:0] & 8'hB0, 8'h80, "status persists");
        wr(ad(0, 0), {8'h00, CMD_READ_ARRAY});
        rd_chk(ad(6, 12'h010), 16'h6666);
        @(posedge core_clk);
        ram_mode <= 1'b0;
    endtask : t_ram_mode
    task automatic t_erase_fail;
        @(posedge core_clk);
        arr_fail <= 1'b1;
        run(ad(6, 12'hFFE), CMD_BLK_ERASE, {8'h00, CMD_CONFIRM}, 1);
        chk(eerr, 1'b1, "erase fail");
        @(posedge core_clk);
        arr_fail <= 1'b0;
        clr();
        run(ad(6, 12'hFFE), CMD_BLK_ERASE, {8'h00, CMD_CONFIRM}, 1);
        chk(eerr, 1'b0, "retry erase");
    endtask : t_erase_fail
    // ------------------------------------------------------------------
    // Sequence, watchdog and verdict.
    // ------------------------------------------------------------------
    task automatic print_verdict;
        if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        #1 t_program();
        t_reprog();
        t_lock();
        t_badseq();
        t_erase_all();
        t_ram_mode();
        t_erase_fail();
        print_verdict();
    end
    initial begin
        #2_000_000;
        fail_count++;
        print_verdict();
    end
endmodule : tb_fcs_sequencer
